// ### mstart_pkg.sv
// Package: shared types and constants for the motor start monitor.
// Assumes: current arrives as an unsigned per-unit magnitude each cycle.
package mstart_pkg;

  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int          CUR_W          = 16;
  localparam int          ACC_W          = 48;
  localparam int          TIME_W         = 32;
  localparam int          CLK_HZ         = 25_000_000;
  localparam int          TICK_US        = 100;
  localparam int          TICK_CYC       = (CLK_HZ / 1_000_000) * TICK_US;
  localparam logic [15:0] TICK_RELOAD    = 16'(TICK_CYC - 1);
  localparam logic [TIME_W-1:0] TIME_ZERO = 32'h0000_0000;
  localparam logic [ACC_W-1:0]  ACC_ZERO  = 48'h0000_0000_0000;

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic {
    PRIN_DEFINITE,
    PRIN_INVERSE
  } principle_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_RUN,
    ST_STALL
  } mon_state_t;

  // Setting bundle held by the operator side
  typedef struct packed {
    principle_t        principle;
    logic              auto_time;
    logic              stall_mon_en;
    logic              speed_sw_en;
    logic [TIME_W-1:0] manual_ticks;
    logic [TIME_W-1:0] hot_stall_ticks;
    logic [TIME_W-1:0] cold_stall_ticks;
    logic [CUR_W-1:0]  nom_start_cur;
    logic [CUR_W-1:0]  detect_cur;
    logic [CUR_W-1:0]  stall_cur;
  } settings_t;

  // Thermal overload function state
  typedef struct packed {
    logic active;
    logic motor_hot;
  } thermal_t;

endpackage : mstart_pkg

// ### i2t_accum.sv
// Squared-current-time accumulator with limit compare.
// Assumes: tick is a one-cycle pulse from the same clock.
module i2t_accum
  import mstart_pkg::*;
#(
  parameter int CW = CUR_W,
  parameter int AW = ACC_W
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          clear,
  input  wire logic          tick,
  input  wire logic [CW-1:0] cur,
  input  wire logic [AW-1:0] limit,
  output logic               over
);
  // Square must fit the sum without loss
  if (AW < 2 * CW) begin : g_acc_width
    $error("accumulator too narrow");
  end

  logic [AW-1:0]   acc_r;
  logic [AW-1:0]   acc_nxt;
  logic [2*CW-1:0] sq;

  assign sq      = cur * cur;
  assign acc_nxt = clear ? '0 : (tick ? acc_r + AW'(sq) : acc_r);
  assign over    = acc_r >= limit;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end
endmodule : i2t_accum

// ### motor_start_monitor.sv
// Motor start and locked-rotor monitor with breaker trip output.
// Assumes: settings static while running; current measured per cycle.
module motor_start_monitor
  import mstart_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire mstart_pkg::settings_t    cfg,
  input  wire mstart_pkg::thermal_t     therm,
  input  wire logic [mstart_pkg::CUR_W-1:0] cur_max,
  input  wire logic                     speed_sw,
  output logic                          trip,
  output logic                          starting,
  output logic                          stalled,
  output logic                          auto_fault
);
  import mstart_pkg::*;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic sw_meta_r;
  logic sw_sync_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_meta_r <= 1'b0;
      sw_sync_r <= 1'b0;
    end else begin
      sw_meta_r <= speed_sw;
      sw_sync_r <= sw_meta_r;
    end
  end

  // ****************************************
  // Time base
  // ****************************************
  logic [15:0] div_r;
  wire         tick = (div_r == 16'h0000);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) div_r <= TICK_RELOAD;
    else div_r <= tick ? TICK_RELOAD : div_r - 16'h0001;
  end

  // ****************************************
  // Permitted time selection
  // ****************************************
  // auto needs active thermal function
  wire auto_ok = cfg.auto_time & therm.active;
  wire [TIME_W-1:0] safe_ticks = therm.motor_hot ? cfg.hot_stall_ticks
                                                 : cfg.cold_stall_ticks;
  wire [TIME_W-1:0] allow_ticks = auto_ok ? safe_ticks : cfg.manual_ticks;
  assign auto_fault = cfg.auto_time & ~therm.active;

  // limit is Inom^2 times allowed time
  wire [ACC_W-1:0] i2t_limit =
    ACC_W'(cfg.nom_start_cur * cfg.nom_start_cur) * ACC_W'(allow_ticks);

  // ****************************************
  // Monitor state machine
  // ****************************************
  mon_state_t        st_r;
  mon_state_t        st_nxt;
  logic [TIME_W-1:0] tmr_r;
  logic              trip_r;
  logic              i2t_over;

  wire above   = cur_max >= cfg.detect_cur;
  wire stallc  = cur_max >= cfg.stall_cur;
  wire timing  = (st_r == ST_START) | (st_r == ST_STALL);
  wire sw_ok   = cfg.speed_sw_en & sw_sync_r;
  wire lim_hit = (cfg.principle == PRIN_DEFINITE) ?
                 (tmr_r >= allow_ticks) : i2t_over;
  // safe stall ceiling ignores the switch
  wire safe_hit = tmr_r >= safe_ticks;
  // trip on limit unless switch extends
  wire trip_now = timing & ((lim_hit & ~sw_ok) | (sw_ok & safe_hit));

  i2t_accum #(.CW(CUR_W), .AW(ACC_W)) u_acc (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clear   (~timing),
    .tick    (tick & timing),
    .cur     (cur_max),
    .limit   (i2t_limit),
    .over    (i2t_over)
  );

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        // no new start while trip stands
        if (above & ~trip_r) st_nxt = ST_START;
      end
      ST_START: begin
        if (trip_now) st_nxt = ST_IDLE;
        else if (~stallc) st_nxt = above ? ST_RUN : ST_IDLE;
      end
      ST_RUN: begin
        if (~above) st_nxt = ST_IDLE;
        else if (stallc & cfg.stall_mon_en) st_nxt = ST_STALL;
      end
      ST_STALL: begin
        if (trip_now) st_nxt = ST_IDLE;
        else if (~stallc) st_nxt = above ? ST_RUN : ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  wire              hold_st  = timing & (st_nxt == st_r);
  wire [TIME_W-1:0] tmr_nxt  = hold_st ? tmr_r + TIME_W'(tick) : TIME_ZERO;
  // Trip holds until current falls, so breaker opening is seen
  wire              trip_nxt = trip_now | (trip_r & above);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_r <= TIME_ZERO;
    end else begin
      tmr_r <= tmr_nxt;
    end
  end

  // trip latch, set wins over release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_r <= 1'b0;
    end else begin
      trip_r <= trip_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign trip     = trip_r;
  assign starting = (st_r == ST_START);
  assign stalled  = (st_r == ST_STALL);

  // ****************************************
  // Checks
  // ****************************************
  a_trip_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(trip) |-> $past(timing)) else $error("trip without timing");
  a_switch_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timing & sw_ok & ~safe_hit) |=> ~$rose(trip))
    else $error("tripped despite speed switch");
  a_safe_ceiling: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timing & sw_ok & safe_hit) |=> trip) else $error("safe stall missed");
  a_def_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timing & ~sw_ok & cfg.principle == PRIN_DEFINITE
     & tmr_r >= allow_ticks) |=> trip) else $error("definite time missed");
  a_i2t_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timing & ~sw_ok & cfg.principle == PRIN_INVERSE & ~i2t_over
     & ~$past(trip)) |=> ~$rose(trip)) else $error("early i2t trip");
  a_auto_sel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (~therm.active) |-> allow_ticks == cfg.manual_ticks)
    else $error("auto without thermal");
  a_stall_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_r == ST_RUN & above & stallc & cfg.stall_mon_en) |=> stalled)
    else $error("stall not watched");
  a_trip_ends: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trip_now |=> (st_r == ST_IDLE)) else $error("start not ended");
  a_no_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_r == ST_IDLE & trip_r) |=> ~starting)
    else $error("start taken while trip stands");
  a_trip_stands: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (trip & above) |=> trip)
    else $error("trip released with current on");
  a_trip_drops: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (trip & ~above & ~trip_now) |=> ~trip)
    else $error("trip kept after current fell");
  a_hot_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (auto_ok & therm.motor_hot) |-> (allow_ticks == cfg.hot_stall_ticks))
    else $error("hot stall time not used");
  a_cold_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (auto_ok & ~therm.motor_hot) |-> (allow_ticks == cfg.cold_stall_ticks))
    else $error("cold stall time not used");
  a_inv_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timing & ~sw_ok & cfg.principle == PRIN_INVERSE & i2t_over) |=> trip)
    else $error("inverse limit missed");
  a_timer_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timing & (st_nxt == st_r) & ~tick) |=> (tmr_r == $past(tmr_r)))
    else $error("timer moved without tick");
  a_sw_extends: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timing & sw_ok & lim_hit & ~safe_hit) |=> ~trip)
    else $error("switch did not extend start");
  a_stall_exit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stalled & ~trip_now & ~stallc & above) |=> (st_r == ST_RUN))
    else $error("stall not left on lower current");

  // ****************************************
  // Coverage
  // ****************************************
  c_start_trip: cover property (@(posedge sys_clk) starting ##1 $rose(trip));
  c_stall_trip: cover property (@(posedge sys_clk) stalled ##1 $rose(trip));
  c_switch_ext: cover property (@(posedge sys_clk) timing & sw_ok & lim_hit);
  c_run: cover property (@(posedge sys_clk) st_r == ST_RUN);
  c_inv_trip: cover property (@(posedge sys_clk)
    (starting & cfg.principle == PRIN_INVERSE) ##1 $rose(trip));
endmodule : motor_start_monitor

// ### motor_model.sv
// Motor, breaker and speed switch as the monitor sees them.
// Assumes: one clock; a trip holds the breaker open until run drops.
module motor_model
  import mstart_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         run,
  input  wire logic [mstart_pkg::CUR_W-1:0] lvl,
  input  wire logic                         spin,
  input  wire logic                         trip,
  output logic [mstart_pkg::CUR_W-1:0]      cur_max,
  output logic                              speed_sw
);
  timeunit 1ns;
  timeprecision 1ns;
  import mstart_pkg::*;
  logic open_r;
  // *****
  // Breaker and shaft
  // *****
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_r   <= 1'b0;
      cur_max  <= 16'h0000;
      speed_sw <= 1'b0;
    end else begin
      // Breaker stays open so no restart races the bench
      open_r   <= trip | (open_r & run);
      cur_max  <= (run && !open_r && !trip) ? lvl : 16'h0000;
      speed_sw <= spin & run;
    end
  end
endmodule : motor_model

// ### motor_start_locked_rotor_monitor_tb.sv
// Self-checking bench for the motor start monitor.
// Assumes: motor_model drives current and speed switch inputs.
module motor_start_locked_rotor_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mstart_pkg::*;
  logic             sys_clk = 1'b0;
  logic             rst_n = 1'b0;
  settings_t        cfg;
  thermal_t         therm = 2'b00;
  logic             run = 1'b0;
  logic             spin = 1'b0;
  logic [CUR_W-1:0] lvl = 16'h0000;
  logic [CUR_W-1:0] cur_max;
  logic             speed_sw, trip, starting, stalled, auto_fault;
  logic [31:0]      seed = 32'h0001_307B;
  int               n_mismatch = 0;
  int               n_tests = 0;

  motor_start_monitor dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg),
    .therm(therm), .cur_max(cur_max), .speed_sw(speed_sw), .trip(trip),
    .starting(starting), .stalled(stalled), .auto_fault(auto_fault));
  motor_model far (.sys_clk(sys_clk), .rst_n(rst_n), .run(run),
    .lvl(lvl), .spin(spin), .trip(trip), .cur_max(cur_max),
    .speed_sw(speed_sw));

  initial forever #20 sys_clk = ~sys_clk;
  // *****
  // Helpers
  // *****
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  // Ticks until the squared-current sum reaches its limit
  function automatic int inv_t(input logic [CUR_W-1:0] c);
    longint lim;
    longint q;
    lim = longint'(cfg.nom_start_cur) * cfg.nom_start_cur * 2;
    q = longint'(c) * c;
    return int'((lim + q - 1) / q);
  endfunction : inv_t

  task automatic check(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %b got %b", nm, e, g);
    end
  endtask : check

  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // One start; st routes through run into a stall first
  task automatic go(input logic [CUR_W-1:0] c, input logic s,
                    input logic st, input int t);
    int n;
    n = 0;
    @(posedge sys_clk);
    lvl  <= c;
    spin <= s;
    run  <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 check("starting", 1'b1, starting);
    if (st) begin
      @(posedge sys_clk);
      lvl <= 16'h0180;
      repeat (6) @(posedge sys_clk);
      #1 check("run_state", 1'b0, starting | stalled);
      @(posedge sys_clk);
      lvl <= c;
      repeat (4) @(posedge sys_clk);
      #1 check("stalled", 1'b1, stalled);
    end
    while (trip !== 1'b1 && n < 50000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    n_tests++;
    if (n < (t - 1) * TICK_CYC || n > (t + 1) * TICK_CYC) begin
      n_mismatch++;
      $display("[ERR] trip_cycles expected %0d got %0d", t * TICK_CYC, n);
    end
    @(posedge sys_clk);
    run <= 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 check("trip_clear", 1'b0, trip);
    @(posedge sys_clk);
  endtask : go

  // About 30 ticks of trips expected; keeps a hang under 100k cycles
  initial begin
    #(38 * 40 * TICK_CYC);
    n_mismatch++;
    complete_run();
  end
  // *****
  // Scenarios
  // *****
  initial begin
    cfg = '0;
    cfg.manual_ticks = 32'h0000_0002;
    cfg.hot_stall_ticks = 32'h0000_0003;
    cfg.cold_stall_ticks = 32'h0000_0004;
    cfg.nom_start_cur = 16'h0600;
    cfg.detect_cur = 16'h0100;
    cfg.stall_cur = 16'h0200;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    seed = xs(seed);
    go(16'h0300 + 16'(seed[9:0]), 1'b0, 1'b0, 2);
    cfg.speed_sw_en <= 1'b1;
    go(16'h0500, 1'b1, 1'b0, 4);
    therm.motor_hot <= 1'b1;
    go(16'h0500, 1'b1, 1'b0, 3);
    go(16'h0500, 1'b0, 1'b0, 2);
    cfg.speed_sw_en <= 1'b0;
    cfg.principle <= PRIN_INVERSE;
    go(16'h0600, 1'b0, 1'b0, 2);
    go(16'h0300, 1'b0, 1'b0, 8);
    seed = xs(seed);
    go(16'h0400 + 16'(seed[9:0]), 1'b0, 1'b0,
       inv_t(16'h0400 + 16'(seed[9:0])));
    cfg.principle <= PRIN_DEFINITE;
    cfg.auto_time <= 1'b1;
    therm.active <= 1'b0;
    #1 check("auto_fault", 1'b1, auto_fault);
    go(16'h0500, 1'b0, 1'b0, 2);
    therm.active <= 1'b1;
    #1 check("auto_fault", 1'b0, auto_fault);
    go(16'h0500, 1'b0, 1'b0, 3);
    cfg.auto_time <= 1'b0;
    cfg.stall_mon_en <= 1'b1;
    go(16'h0300, 1'b0, 1'b1, 2);
    complete_run();
  end
endmodule : motor_start_locked_rotor_monitor_tb
